// ==== usx_regs.svh ====
`ifndef USX_REGS_SVH
`define USX_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define USX_OFF_DATA       8'h00
`define USX_OFF_IE_DLH     8'h04
`define USX_OFF_LINE_CTRL  8'h0C
`define USX_OFF_LINE_STAT  8'h14
`define USX_OFF_CTRL       8'h30
`define USX_OFF_SYNC_CTRL  8'h34

// ==========================================================
// Field positions
`define USX_CTRL_EN_BIT    0
`define USX_CTRL_MODE_LSB  1
`define USX_CTRL_RX_ENABLE_BIT_BIT  6
`define USX_CTRL_TX_ENABLE_BIT_BIT  7
`define USX_SYNC_IDLE_BIT  0
`define USX_SYNC_EDGE_BIT  1
`define USX_LC_PAR_EN_BIT  3
`define USX_LC_EVEN_BIT    4
`define USX_LC_BREAK_BIT   6
`define USX_LC_DIVISOR_ACCESS_SELECT_BIT    7
`define USX_IE_MASK        32'h0000071F
`define USX_LS_RDR_BIT     0
`define USX_LS_OVR_BIT     1
`define USX_LS_THRE_BIT    5
`define USX_LS_TEMT_BIT    6

// ==========================================================
// Reset values and encodings
`define USX_RST_WORD       32'h00000000
`define USX_MODE_SYNC      3'h4
`define USX_RESP_OKAY      2'h0
`define USX_RESP_SLVERR    2'h2

// ==========================================================
// Timing: sub-bit ticks per bit and the clock-edge point
`define USX_TICKS_PER_BIT  16
`define USX_SUB_LAST       4'hF
`define USX_SUB_HALF       4'h8

`endif

// ==== usx_pkg.sv ====
// ==========================================================
// Shared types
package usx_pkg;

  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    USX_IDLE   = 3'h0,
    USX_START  = 3'h1,
    USX_DATA   = 3'h3,
    USX_PARITY = 3'h2,
    USX_STOP   = 3'h6
  } usx_tx_state_t;

  typedef logic [7:0] usx_byte_t;

endpackage : usx_pkg

// ==== usx_fifo.sv ====
`timescale 1ns/1ns
// ==========================================================
// Character FIFO with registered head data
module usx_fifo import usx_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  full,
  // Read side
  input  wire logic             pop,
  output logic [WIDTH-1:0]      rd_data,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("usx_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;
  logic [AW-1:0]    next_rd_ptr;

  assign full        = (count == (AW+1)'(DEPTH));
  assign empty       = (count == '0);
  assign do_push     = push && !full;
  assign do_pop      = pop && !empty;
  assign next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count  <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Head word bypasses the array when it is being written this cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= '0;
    end else if (do_push && wr_ptr == next_rd_ptr) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[next_rd_ptr];
    end
  end

endmodule : usx_fifo

// ==== usx_baud.sv ====
`timescale 1ns/1ns
// ==========================================================
// Baud generator: one tick per divisor clocks (16x bit rate)
module usx_baud import usx_pkg::*; (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Divisor and tick
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count;
  logic [15:0] reload;

  // A zero divisor behaves like one, so the tick never stops
  assign reload = (divisor == 16'h0000) ? 16'h0000
                                        : divisor - 16'h0001;
  assign tick   = (count == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
    end else if (tick || count > reload) begin
      count <= reload;
    end else begin
      count <= count - 16'h0001;
    end
  end

endmodule : usx_baud

// ==== usx_top.sv ====
`timescale 1ns/1ns
`include "usx_regs.svh"

module usx_top import usx_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Serial pins
  output logic             serial_tx_line,
  input  wire logic        serial_rx_line,
  output logic             serial_clk
);

  // ==========================================================
  // Register state
  logic        usart_en;
  logic [2:0]  mode;
  logic        rx_enable_bit;
  logic        tx_enable_bit;
  logic        clock_idle_level;
  logic        clock_sample_edge;
  logic [7:0]  line_control_reg;
  logic [7:0]  divisor_low;
  logic [7:0]  divisor_high_byte;
  logic [31:0] interrupt_enable;
  logic        overrun;
  logic        tx_idle;

  logic        divisor_access_select;
  logic        sync_on;
  logic [3:0]  word_len;
  logic        tick;

  assign divisor_access_select = line_control_reg[`USX_LC_DIVISOR_ACCESS_SELECT_BIT];
  assign sync_on  = usart_en && (mode == `USX_MODE_SYNC);
  assign word_len = 4'h5 + {2'h0, line_control_reg[1:0]};

  // ==========================================================
  // FIFOs and baud generator
  logic      tx_push;
  logic      tx_pop;
  logic      tx_full;
  logic      tx_empty;
  usx_byte_t tx_head;
  logic      rx_push;
  logic      rx_pop;
  logic      rx_full;
  logic      rx_empty;
  usx_byte_t rx_head;
  usx_byte_t rx_char;
  logic [31:0] w_word;

  usx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .push    (tx_push),
    .wr_data (w_word[7:0]),
    .full    (tx_full),
    .pop     (tx_pop),
    .rd_data (tx_head),
    .empty   (tx_empty)
  );

  usx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .push    (rx_push),
    .wr_data (rx_char),
    .full    (rx_full),
    .pop     (rx_pop),
    .rd_data (rx_head),
    .empty   (rx_empty)
  );

  usx_baud u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor ({divisor_high_byte, divisor_low}),
    .tick    (tick)
  );

  // ==========================================================
  // AXI4-Lite write channel: address and data taken in either order
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       wr_fire;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_word <= `USX_RST_WORD;
      w_byte <= 8'h00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_word <= s_axi_wdata;
      w_byte <= {4'h0, s_axi_wstrb};
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  logic wr_mapped;
  logic wr_lane0;
  logic wr_lane1;

  assign wr_lane0 = w_byte[0];
  assign wr_lane1 = w_byte[1];
  always_comb begin
    case (aw_addr)
      `USX_OFF_DATA, `USX_OFF_IE_DLH, `USX_OFF_LINE_CTRL,
      `USX_OFF_LINE_STAT, `USX_OFF_CTRL, `USX_OFF_SYNC_CTRL:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  // Transmit push uses the latched word, so the FIFO input is w_word
  assign tx_push = wr_fire && wr_lane0 && aw_addr == `USX_OFF_DATA
                   && !divisor_access_select;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `USX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `USX_RESP_OKAY : `USX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor_low       <= 8'h00;
      divisor_high_byte <= 8'h00;
      interrupt_enable  <= `USX_RST_WORD;
    end else if (wr_fire && divisor_access_select && wr_lane0) begin
      if (aw_addr == `USX_OFF_DATA) begin
        divisor_low <= w_word[7:0];
      end else if (aw_addr == `USX_OFF_IE_DLH) begin
        divisor_high_byte <= w_word[7:0];
      end
    end else if (wr_fire && !divisor_access_select
                 && aw_addr == `USX_OFF_IE_DLH) begin
      // Enables are stored only; this block raises no interrupt itself
      if (wr_lane0) begin
        interrupt_enable[7:0] <= w_word[7:0] & 8'(`USX_IE_MASK);
      end
      if (wr_lane1) begin
        interrupt_enable[15:8] <= w_word[15:8] & 8'h07;
      end
    end
  end

  // Polarity and phase are taken at any time; software keeps them
  // steady while either direction is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usart_en          <= 1'b0;
      mode              <= 3'h0;
      rx_enable_bit     <= 1'b0;
      tx_enable_bit     <= 1'b0;
      clock_idle_level  <= 1'b0;
      clock_sample_edge <= 1'b0;
      line_control_reg  <= 8'h00;
    end else if (wr_fire && wr_lane0) begin
      case (aw_addr)
        `USX_OFF_CTRL: begin
          usart_en      <= w_word[`USX_CTRL_EN_BIT];
          mode          <= w_word[`USX_CTRL_MODE_LSB +: 3];
          rx_enable_bit <= w_word[`USX_CTRL_RX_ENABLE_BIT_BIT];
          tx_enable_bit <= w_word[`USX_CTRL_TX_ENABLE_BIT_BIT];
        end
        `USX_OFF_SYNC_CTRL: begin
          clock_idle_level  <= w_word[`USX_SYNC_IDLE_BIT];
          clock_sample_edge <= w_word[`USX_SYNC_EDGE_BIT];
        end
        `USX_OFF_LINE_CTRL: begin
          line_control_reg <= w_word[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        rd_take;
  logic [7:0]  ls_bits;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  // Reading the head character pops it
  assign rx_pop = rd_take && s_axi_araddr == `USX_OFF_DATA
                  && !divisor_access_select;

  always_comb begin
    ls_bits = 8'h00;
    ls_bits[`USX_LS_RDR_BIT]  = !rx_empty;
    ls_bits[`USX_LS_OVR_BIT]  = overrun;
    ls_bits[`USX_LS_THRE_BIT] = tx_empty;
    ls_bits[`USX_LS_TEMT_BIT] = tx_empty && tx_idle;
  end

  always_comb begin
    next_rdata = `USX_RST_WORD;
    next_rresp = `USX_RESP_OKAY;
    case (s_axi_araddr)
      `USX_OFF_DATA:
        if (divisor_access_select) begin
          next_rdata = {24'h0, divisor_low};
        end else begin
          next_rdata = {24'h0, rx_head};
        end
      `USX_OFF_IE_DLH:
        if (divisor_access_select) begin
          next_rdata = {24'h0, divisor_high_byte};
        end else begin
          next_rdata = interrupt_enable;
        end
      `USX_OFF_LINE_CTRL: next_rdata = {24'h0, line_control_reg};
      `USX_OFF_LINE_STAT: next_rdata = {24'h0, ls_bits};
      `USX_OFF_CTRL:
        next_rdata = {24'h0, tx_enable_bit, rx_enable_bit, 2'h0,
                      mode, usart_en};
      `USX_OFF_SYNC_CTRL:
        next_rdata = {30'h0, clock_sample_edge, clock_idle_level};
      default: next_rresp = `USX_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `USX_RST_WORD;
      s_axi_rresp  <= `USX_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Transmitter
  usx_tx_state_t state;
  logic [3:0]    sub;
  logic [3:0]    bit_cnt;
  usx_byte_t     tx_shift;
  logic          parity;
  logic          send_break;
  logic          bit_end;

  assign tx_idle    = (state == USX_IDLE);
  assign send_break = line_control_reg[`USX_LC_BREAK_BIT];
  assign bit_end    = tick && sub == `USX_SUB_LAST;
  // Characters start only with the transmitter enabled and no break
  assign tx_pop = tx_idle && tick && sync_on && tx_enable_bit
                  && !tx_empty && !send_break;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= USX_IDLE;
      sub      <= 4'h0;
      bit_cnt  <= 4'h0;
      tx_shift <= 8'h00;
      parity   <= 1'b0;
    end else begin
      if (tick) begin
        sub <= sub + 4'h1;
      end
      case (state)
        USX_IDLE:
          if (tx_pop) begin
            state    <= USX_START;
            sub      <= 4'h1;
            tx_shift <= tx_head;
            parity   <= !line_control_reg[`USX_LC_EVEN_BIT];
          end
        USX_START:
          if (bit_end) begin
            state   <= USX_DATA;
            bit_cnt <= 4'h0;
          end
        USX_DATA:
          if (bit_end) begin
            parity   <= parity ^ tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            bit_cnt  <= bit_cnt + 4'h1;
            if (bit_cnt == word_len - 4'h1) begin
              state <= line_control_reg[`USX_LC_PAR_EN_BIT]
                       ? USX_PARITY : USX_STOP;
            end
          end
        USX_PARITY:
          if (bit_end) begin
            state <= USX_STOP;
          end
        USX_STOP:
          if (bit_end) begin
            state <= USX_IDLE;
          end
        default: state <= USX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Serial outputs: line and clock both from flip-flops
  logic clk_active;
  logic next_serial_clk;

  // Phase 0: clock active in the second half, leading edge mid-bit.
  // Phase 1: active in the first half, trailing edge mid-bit.
  assign clk_active = (state == USX_DATA || state == USX_PARITY)
                      && (clock_sample_edge ? sub < `USX_SUB_HALF
                                            : sub >= `USX_SUB_HALF);
  assign next_serial_clk = clock_idle_level ^ clk_active;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_line <= 1'b1;
      serial_clk     <= 1'b0;
    end else begin
      serial_clk <= next_serial_clk;
      if (send_break && tx_idle) begin
        serial_tx_line <= 1'b0;
      end else begin
        case (state)
          USX_START:  serial_tx_line <= 1'b0;
          USX_DATA:   serial_tx_line <= tx_shift[0];
          USX_PARITY: serial_tx_line <= parity;
          default:    serial_tx_line <= 1'b1;
        endcase
      end
    end
  end
  // The clock pin has no input path at all, so no transfer can be
  // timed from outside.

  // ==========================================================
  // Receiver: two-flop synchroniser, one sample per data bit
  logic      rx_meta;
  logic      rx_sync;
  logic      rx_sample;
  usx_byte_t rx_shift;
  logic      rx_bits_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_rx_line;
      rx_sync <= rx_meta;
    end
  end

  // Sample where the chosen edge is about to appear on the pin
  assign rx_sample = sync_on && rx_enable_bit && state == USX_DATA
                     && next_serial_clk != serial_clk
                     && (next_serial_clk != clock_idle_level)
                        == !clock_sample_edge;
  assign rx_char = rx_shift >> (4'h8 - word_len);
  assign rx_push = rx_bits_in && state == USX_STOP && bit_end;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift   <= 8'h00;
      rx_bits_in <= 1'b0;
    end else if (rx_sample) begin
      rx_shift   <= {rx_sync, rx_shift[7:1]};
      rx_bits_in <= 1'b1;
    end else if (tx_pop || rx_push) begin
      rx_bits_in <= 1'b0;
    end
  end

  // Overrun: a character lost to a full FIFO; reading status clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun <= 1'b0;
    end else if (rx_push && rx_full) begin
      overrun <= 1'b1;
    end else if (rd_take && s_axi_araddr == `USX_OFF_LINE_STAT) begin
      overrun <= 1'b0;
    end
  end

endmodule : usx_top

// ==== usx_top_properties.sv ====
`timescale 1ns/1ns
// ==========================================================
// Port-level checks of the register bus and serial pins
module usx_top_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Serial
  input wire logic        serial_tx_line,
  input wire logic        serial_clk
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_idle: assert property ($rose(aresetn) |->
    serial_tx_line && !serial_clk && !s_axi_bvalid && !s_axi_rvalid)
    else $error("lines not idle after reset");
  a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
  a_aw_blocks: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready)
    else $error("ready while a word is held");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("response not released");
endmodule : usx_top_properties

// ==== usx_peer.sv ====
`timescale 1ns/1ns
// ==========================================================
// Synchronous peripheral on the serial side
module usx_peer (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Serial pins
  input  wire logic       sclk,
  input  wire logic       txd,
  output logic            rxd,
  // Set-up and results
  input  wire logic       idle,
  input  wire logic       phase,
  input  wire logic       load,
  input  wire logic [7:0] reply,
  output logic [7:0]      cap,
  output logic [7:0]      pc
);
  logic       prv;
  logic [7:0] sh;
  assign rxd = sh[0];
  // Reply moves on the edge opposite the sampling one; spent bits
  // refill inverted so a late sample never sees a stale bit
  always_ff @(posedge aclk) begin
    prv <= sclk;
    if (!aresetn || load) begin
      pc <= 8'h00;
      sh <= reply;
    end else if (sclk != prv) begin
      if ((sclk != idle) != phase) begin
        cap <= {txd, cap[7:1]};
        pc  <= pc + 8'h01;
      end else if (pc != 8'h00) begin
        sh <= {~sh[0], sh[7:1]};
      end
    end
  end
endmodule : usx_peer

// ==== tb_usx_top.sv ====
`timescale 1ns/1ns
`include "usx_regs.svh"
// ==========================================================
// Bench top
module tb_usx_top;
  logic        aclk, aresetn, awv, wv, br, arv, rr, ld, idl, ph;
  logic        awr, wr, bv, arr, rv, tx, rxl, sck;
  logic [7:0]  awa, ara, rpl, cap, pc;
  logic [31:0] wd, rd, r;
  logic [1:0]  bp, rp, e;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  usx_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rp), .serial_tx_line(tx),
    .serial_rx_line(rxl), .serial_clk(sck));
  usx_peer i_peer (.aclk(aclk), .aresetn(aresetn), .sclk(sck),
    .txd(tx), .rxd(rxl), .idle(idl), .phase(ph), .load(ld),
    .reply(rpl), .cap(cap), .pc(pc));
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  // ==========================================================
  // Bus and check tasks
  task summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task tmo;
    n_mismatch++;
    summarize();
  endtask : tmo
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    int   k;
    logic ta, tw, hb;
    @(posedge aclk);
    awv <= 1; wv <= 1; awa <= a; wd <= d; br <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge aclk);
      ta = awv && awr; tw = wv && wr; hb = bv;
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (hb) break;
    end
    br <= 0;
    if (k == 100) tmo();
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d,
           output logic [1:0] p);
    int   k;
    logic ta, hv;
    @(posedge aclk);
    arv <= 1; ara <= a; rr <= 1;
    for (k = 0; k < 100; k++) begin
      @(negedge aclk);
      ta = arv && arr; hv = rv; d = rd; p = rp;
      @(posedge aclk);
      if (ta) arv <= 0;
      if (hv) break;
    end
    rr <= 0;
    if (k == 100) tmo();
  endtask : axr
  task wpc(input logic [7:0] v, output int c);
    for (c = 0; c < 5000 && pc !== v; c++) @(negedge aclk);
    if (c == 5000) tmo();
  endtask : wpc
  task load_peer(input logic [7:0] v);
    @(posedge aclk);
    ld <= 1; rpl <= v;
    @(posedge aclk);
    ld <= 0;
  endtask : load_peer
  // ==========================================================
  // Scenarios
  task t_regs;
    axr(`USX_OFF_IE_DLH, r, e);
    chk("ie_reset", 32'h0, r);
    axw(`USX_OFF_IE_DLH, 32'hFFFFFFFF);
    axr(`USX_OFF_IE_DLH, r, e);
    chk("ie_bits", `USX_IE_MASK, r);
    axw(`USX_OFF_LINE_CTRL, 32'h83);
    axr(`USX_OFF_DATA, r, e);
    chk("div_low", 32'h0, r);
    axw(`USX_OFF_IE_DLH, 32'hAB);
    axr(`USX_OFF_IE_DLH, r, e);
    chk("div_high", 32'hAB, r);
    axw(`USX_OFF_IE_DLH, 32'h0);
    axw(`USX_OFF_LINE_CTRL, 32'h03);
    axr(`USX_OFF_IE_DLH, r, e);
    chk("ie_back", `USX_IE_MASK, r);
    axr(8'h40, r, e);
    chk("hole_data", 32'h0, r);
    chk("hole_resp", {30'h0, `USX_RESP_SLVERR}, {30'h0, e});
    axw(8'h40, 32'h0);
    chk("hole_wresp", {30'h0, `USX_RESP_SLVERR}, {30'h0, bp});
  endtask : t_regs
  // Every idle level and phase, with divisors 0 to 3
  task t_frames;
    int c, s, dd;
    for (int i = 0; i < 4; i++) begin
      dd = (i == 0) ? 1 : i;
      axw(`USX_OFF_CTRL, 32'h0);
      axw(`USX_OFF_SYNC_CTRL, i);
      axw(`USX_OFF_LINE_CTRL, 32'h83);
      axw(`USX_OFF_DATA, i);
      axw(`USX_OFF_LINE_CTRL, 32'h03);
      axw(`USX_OFF_CTRL, 32'hC9);
      idl <= i[0]; ph <= i[1];
      load_peer(8'h3C ^ 8'(i));
      chk("clk_idle", i[0], sck);
      axw(`USX_OFF_DATA, 32'hA5 ^ i);
      wpc(8'h01, c);
      wpc(8'h08, s);
      chk("bit_span", 112 * dd, s);
      chk("tx_byte", 8'hA5 ^ 8'(i), cap);
      repeat (40 * dd) @(posedge aclk);
      chk("clk_after", i[0], sck);
      chk("tx_idle", 1, tx);
      axr(`USX_OFF_LINE_STAT, r, e);
      chk("line_stat", 32'h61, r);
      axr(`USX_OFF_DATA, r, e);
      chk("rx_byte", rpl, r);
    end
  endtask : t_frames
  task t_gate;
    int c;
    load_peer(8'h00);
    axw(`USX_OFF_CTRL, 32'hC1);
    axw(`USX_OFF_DATA, 32'h5A);
    repeat (300) @(posedge aclk);
    chk("mode_gate", 0, pc);
    axw(`USX_OFF_CTRL, 32'h49);
    repeat (300) @(posedge aclk);
    chk("tx_gate", 0, pc);
    axw(`USX_OFF_CTRL, 32'hC9);
    wpc(8'h08, c);
    chk("late_byte", 8'h5A, cap);
  endtask : t_gate
  initial begin
    aresetn = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; ld = 0;
    idl = 0; ph = 0; awa = 0; ara = 0; rpl = 0; wd = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_frames();
    t_gate();
    summarize();
  end
endmodule : tb_usx_top
bind usx_top usx_top_properties i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .serial_tx_line(serial_tx_line), .serial_clk(serial_clk));
